// *** skd_decode.sv ***
// Software-register, watchdog and range-select decoder
`include "skd_defines.svh"

module skd_decode #(
   parameter int unsigned WDT_CYCLES = `SKD_WDT_CYCLES,
   parameter int unsigned NUM_CH     = `SKD_NUM_CH
) (
   input  wire logic                              clk_sys,
   input  wire logic                              rst,
   input  wire logic                              sclk,
   input  wire logic                              sync_n,
   input  wire logic                              serial_data_input,
   input  wire logic                              wdt_enable,
   output logic                                   alert,
   output logic                                   status_echo,
   output logic                                   soft_reset,
   output logic                                   keepalive_seen,
   output skd_pkg::skd_range_t [NUM_CH-1:0]       range_select_bits
);

   skd_pkg::skd_frame_t frame;
   logic                wdt_en_meta_r;
   logic                wdt_en_r;

   skd_rx u_rx (
      .clk_sys           (clk_sys),
      .rst               (rst),
      .sclk              (sclk),
      .sync_n            (sync_n),
      .serial_data_input (serial_data_input),
      .frame             (frame)
   );

   function automatic skd_pkg::skd_range_t range_of(input logic [2:0] code);
      case (code)
         `SKD_RANGE_4_20: range_of = skd_pkg::SKD_RNG_4_20;
         `SKD_RANGE_0_20: range_of = skd_pkg::SKD_RNG_0_20;
         `SKD_RANGE_0_24: range_of = skd_pkg::SKD_RNG_0_24;
         default:         range_of = skd_pkg::SKD_RNG_NONE;
      endcase
   endfunction : range_of

   // Watchdog enable may come from another domain
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wdt_en_meta_r <= 1'b0;
         wdt_en_r <= 1'b0;
      end else begin
         wdt_en_meta_r <= wdt_enable;
         wdt_en_r <= wdt_en_meta_r;
      end
   end

   logic        sw_hit;
   logic        ctrl_hit;
   logic [11:0] code;
   logic [2:0]  prefix;

   assign prefix   = frame.data[`SKD_PREFIX_MSB:`SKD_PREFIX_LSB];
   assign code     = frame.data[`SKD_CODE_MSB:`SKD_CODE_LSB];
   assign sw_hit   = frame.valid && prefix == `SKD_SW_PREFIX;
   assign ctrl_hit = frame.valid && prefix == `SKD_CTRL_PREFIX;

   logic                              soft_rst_r, soft_rst_nxt;
   logic                              rst_int;
   logic                              echo_r, echo_nxt;
   logic                              ka_r, ka_nxt;
   logic                              alert_r, alert_nxt;
   logic [31:0]                       wdt_cnt_r, wdt_cnt_nxt;
   skd_pkg::skd_range_t [NUM_CH-1:0]  range_r, range_nxt;
   skd_pkg::skd_range_t               new_range;
   logic [1:0]                        ch_sel;
   logic                              ka_hit;
   logic                              wdt_expired;

   // Soft reset acts one cycle after its frame, clearing echo, keep-alive, watchdog and range state but not the receiver or enable synchroniser
   assign rst_int = rst || soft_rst_r;
   assign ch_sel = frame.data[`SKD_CH_MSB:`SKD_CH_LSB];
   assign new_range = range_of(frame.data[`SKD_RANGE_MSB:`SKD_RANGE_LSB]);
   assign ka_hit = sw_hit && code == `SKD_KEEPALIVE_CODE;
   assign wdt_expired = wdt_cnt_r >= WDT_CYCLES - 1;

   // Pulse cannot retrigger on the cycle after itself
   always_comb begin
      soft_rst_nxt = 1'b0;
      if (sw_hit && code == `SKD_RESET_CODE && !soft_rst_r) begin
         soft_rst_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= soft_rst_nxt;
      end
   end

   always_comb begin
      echo_nxt = echo_r;
      if (sw_hit) begin
         echo_nxt = frame.data[`SKD_ECHO_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst_int) begin
         echo_r <= 1'b0;
      end else begin
         echo_r <= echo_nxt;
      end
   end

   always_comb begin
      ka_nxt = 1'b0;
      alert_nxt = alert_r;
      wdt_cnt_nxt = wdt_cnt_r;
      if (!wdt_en_r) begin
         // Disabled watchdog never faults
         wdt_cnt_nxt = 32'h0000_0000;
         alert_nxt = 1'b0;
      end else if (ka_hit) begin
         wdt_cnt_nxt = 32'h0000_0000;
         alert_nxt = 1'b0;
         ka_nxt = 1'b1;
      end else if (wdt_expired) begin
         // Count parks at the limit so the alert holds until serviced
         alert_nxt = 1'b1;
      end else begin
         wdt_cnt_nxt = wdt_cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst_int) begin
         ka_r <= 1'b0;
         alert_r <= 1'b0;
         wdt_cnt_r <= 32'h0000_0000;
      end else begin
         ka_r <= ka_nxt;
         alert_r <= alert_nxt;
         wdt_cnt_r <= wdt_cnt_nxt;
      end
   end

   // Reserved codes are ignored so a bad write keeps the last range
   genvar gc;
   generate
      for (gc = 0; gc < NUM_CH; gc++) begin : g_range
         always_comb begin
            range_nxt[gc] = range_r[gc];
            if (ctrl_hit && new_range != skd_pkg::SKD_RNG_NONE && 32'(ch_sel) == 32'(gc)) begin
               range_nxt[gc] = new_range;
            end
         end

         always_ff @(posedge clk_sys) begin
            if (rst_int) begin
               range_r[gc] <= skd_pkg::SKD_RNG_NONE;
            end else begin
               range_r[gc] <= range_nxt[gc];
            end
         end
      end
   endgenerate

   assign alert = alert_r;
   assign status_echo = echo_r;
   assign soft_reset = soft_rst_r;
   assign keepalive_seen = ka_r;
   assign range_select_bits = range_r;

endmodule : skd_decode

// *** skd_defines.svh ***
// Constants for the software-register and range decoder
`ifndef SKD_DEFINES_SVH
`define SKD_DEFINES_SVH

`define SKD_WORD_BITS        16
`define SKD_PREFIX_MSB       15
`define SKD_PREFIX_LSB       13
`define SKD_SW_PREFIX        3'h4
`define SKD_CTRL_PREFIX      3'h2
`define SKD_ECHO_BIT         12
`define SKD_CODE_MSB         11
`define SKD_CODE_LSB         0
`define SKD_RESET_CODE       12'h555
`define SKD_KEEPALIVE_CODE   12'h195
`define SKD_CH_MSB           12
`define SKD_CH_LSB           11
`define SKD_RANGE_MSB        2
`define SKD_RANGE_LSB        0
`define SKD_RANGE_4_20       3'h4
`define SKD_RANGE_0_20       3'h5
`define SKD_RANGE_0_24       3'h6
`define SKD_STATUS_ECHO_POS  11
`define SKD_CLK_MHZ          25
`define SKD_WDT_TIMEOUT_US   1000
`define SKD_WDT_CYCLES       (`SKD_WDT_TIMEOUT_US * `SKD_CLK_MHZ)
`define SKD_NUM_CH           4

`endif

// *** skd_pkg.sv ***
// Types shared by the receiver and the decoder
package skd_pkg;

   typedef enum logic [1:0] {
      SKD_RNG_NONE,
      SKD_RNG_4_20,
      SKD_RNG_0_20,
      SKD_RNG_0_24
   } skd_range_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } skd_frame_t;

endpackage : skd_pkg

// *** skd_rx.sv ***
// Serial frame receiver sampled by the system clock
`include "skd_defines.svh"

module skd_rx (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              sclk,
   input  wire logic              sync_n,
   input  wire logic              serial_data_input,
   output skd_pkg::skd_frame_t    frame
);

   logic [2:0] pin_meta_r;
   logic [2:0] pin_sync_r;
   logic       sclk_prev_r;
   logic       sync_prev_r;

   // Two-stage synchronisers for sclk, sync_n, data
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               pin_meta_r[g] <= 1'b1;
               pin_sync_r[g] <= 1'b1;
            end else begin
               pin_meta_r[g] <= (g == 0) ? sclk : ((g == 1) ? sync_n : serial_data_input);
               pin_sync_r[g] <= pin_meta_r[g];
            end
         end
      end
   endgenerate

   logic [15:0]         shift_r, shift_nxt;
   logic [4:0]          cnt_r, cnt_nxt;
   skd_pkg::skd_frame_t frame_r, frame_nxt;

   always_comb begin
      shift_nxt = shift_r;
      cnt_nxt = cnt_r;
      frame_nxt = frame_r;
      frame_nxt.valid = 1'b0;
      if (pin_sync_r[1]) begin
         cnt_nxt = 5'h00;
      end else if (sclk_prev_r && !pin_sync_r[0] && cnt_r != 5'h1F) begin
         // Data sampled on falling clock edge, MSB first
         shift_nxt = {shift_r[14:0], pin_sync_r[2]};
         cnt_nxt = cnt_r + 5'h01;
      end
      // Only an exact 16-bit frame is acted upon
      if (pin_sync_r[1] && !sync_prev_r && cnt_r == 5'(`SKD_WORD_BITS)) begin
         frame_nxt.valid = 1'b1;
         frame_nxt.data = shift_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         shift_r <= 16'h0000;
         cnt_r <= 5'h00;
         frame_r <= '0;
         sclk_prev_r <= 1'b1;
         sync_prev_r <= 1'b1;
      end else begin
         shift_r <= shift_nxt;
         cnt_r <= cnt_nxt;
         frame_r <= frame_nxt;
         sclk_prev_r <= pin_sync_r[0];
         sync_prev_r <= pin_sync_r[1];
      end
   end

   assign frame = frame_r;

endmodule : skd_rx

// *** skd_decode_assertions.sv ***
// Port checks for the software-register decoder
module skd_decode_assertions #(
   parameter int unsigned WDT_CYCLES = 25000,
   parameter int unsigned NUM_CH     = 4
) (
   input wire logic                              clk_sys,
   input wire logic                              rst,
   input wire logic                              sclk,
   input wire logic                              sync_n,
   input wire logic                              serial_data_input,
   input wire logic                              wdt_enable,
   input wire logic                              alert,
   input wire logic                              status_echo,
   input wire logic                              soft_reset,
   input wire logic                              keepalive_seen,
   input wire skd_pkg::skd_range_t [NUM_CH-1:0] range_select_bits
);
   int unsigned idle_r;
   int unsigned idle_nxt;
   // Starts before the design's synchronisers see enable, so bounds carry slack
   always_comb begin
      idle_nxt = (!wdt_enable || keepalive_seen || soft_reset) ? 0 : idle_r + 1;
   end
   always_ff @(posedge clk_sys) begin
      idle_r <= rst ? 0 : idle_nxt;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_off; !wdt_enable [*6]; endsequence
   sequence s_clear; !status_echo && !alert && range_select_bits == '0; endsequence
   property p_sr_pulse; soft_reset |=> !soft_reset; endproperty
   property p_sr_clear; soft_reset |-> ##2 s_clear; endproperty
   property p_ka_pulse; keepalive_seen |=> !keepalive_seen; endproperty
   property p_ka_alert; keepalive_seen |-> ##1 !alert; endproperty
   property p_off; s_off |-> !keepalive_seen && !alert; endproperty
   property p_alert_late; idle_r == WDT_CYCLES + 8 |-> alert; endproperty
   property p_alert_early; $rose(alert) |-> idle_r >= WDT_CYCLES - 1; endproperty
   property p_echo_frame; $changed(status_echo) |-> sync_n; endproperty
   property p_rng_frame; $changed(range_select_bits) |-> sync_n; endproperty
   a_sr_pulse: assert property (p_sr_pulse) else $error("reset pulse too long");
   a_sr_clear: assert property (p_sr_clear) else $error("state kept after reset");
   a_ka_pulse: assert property (p_ka_pulse) else $error("keep-alive pulse too long");
   a_ka_alert: assert property (p_ka_alert) else $error("alert kept after keep-alive");
   a_off: assert property (p_off) else $error("watchdog active while off");
   a_alert_late: assert property (p_alert_late) else $error("alert missing");
   a_alert_early: assert property (p_alert_early) else $error("alert too early");
   a_echo_frame: assert property (p_echo_frame) else $error("echo moved in frame");
   a_rng_frame: assert property (p_rng_frame) else $error("range moved in frame");
endmodule : skd_decode_assertions

// *** skd_host.sv ***
// Host model driving the serial link
module skd_host (
   output logic sclk,
   output logic sync_n,
   output logic serial_data_input
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      serial_data_input = 1'b0;
   end
   // Edges sit off the 40 ns grid so sampling never races
   task automatic send(input logic [15:0] w);
      #13 sync_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         serial_data_input = w[i];
         #160 sclk = 1'b0;
         #160 sclk = 1'b1;
      end
      #160 sync_n = 1'b1;
      serial_data_input = ~w[0]; // Released line must not hold the last bit
      #400;
   endtask : send
endmodule : skd_host

// *** testbench.sv ***
// Self-checking bench for the software-register decoder
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned WDT = 200;
   logic                       clk_sys = 1'b0;
   logic                       rst = 1'b1;
   logic                       wdt_enable = 1'b0;
   logic                       sclk, sync_n, serial_data_input;
   logic                       alert, status_echo, soft_reset, keepalive_seen;
   skd_pkg::skd_range_t [3:0]  range_select_bits;
   logic [7:0]                 rng_exp = 8'h00;
   int                         error_cnt = 0;
   int                         total_checks = 0;
   int                         ka_cnt = 0;
   int                         sr_cnt = 0;
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (keepalive_seen === 1'b1) ka_cnt++;
      if (soft_reset === 1'b1) sr_cnt++;
   end
   skd_host i_skd_host (.sclk(sclk), .sync_n(sync_n), .serial_data_input(serial_data_input));
   skd_decode #(.WDT_CYCLES(WDT), .NUM_CH(4)) i_skd_decode (
      .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .sync_n(sync_n), .serial_data_input(serial_data_input),
      .wdt_enable(wdt_enable), .alert(alert), .status_echo(status_echo), .soft_reset(soft_reset),
      .keepalive_seen(keepalive_seen), .range_select_bits(range_select_bits));
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] w);
      i_skd_host.send(w);
      @(negedge clk_sys);
   endtask : wr
   function automatic logic [1:0] rng_map(input logic [2:0] c, input logic [1:0] old);
      return (c inside {3'h4, 3'h5, 3'h6}) ? c[1:0] + 2'h1 : old;
   endfunction : rng_map
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #1ms;
      error_cnt++;
      give_verdict();
   end
   initial begin
      logic [11:0] code;
      logic        e;
      int          ch;
      void'($urandom(32'hC59A));
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(negedge clk_sys);
      chk("outputs", 8'h00, {4'h0, alert, status_echo, soft_reset, keepalive_seen});
      chk("reset range", 8'h00, range_select_bits);
      $display("test reset done");
      for (int i = 0; i < 32; i++) begin
         ch = i / 8;
         wr({3'h2, 2'(ch), 8'($urandom), 3'(i)});
         rng_exp[2*ch +: 2] = rng_map(3'(i), rng_exp[2*ch +: 2]);
         chk("range", rng_exp, range_select_bits);
      end
      $display("test range done");
      for (int i = 0; i < 8; i++) begin
         e = 1'($urandom);
         code = (i == 7) ? 12'h554 : 12'($urandom);
         if (code == 12'h555 || code == 12'h195) code = 12'h0AA;
         wr({3'h4, e, code});
         chk("echo", {7'h00, e}, {7'h00, status_echo});
      end
      chk("range kept", rng_exp, range_select_bits);
      chk("no pulses", 8'h00, 8'(ka_cnt + sr_cnt));
      $display("test echo done");
      wr(16'h8195);
      repeat (WDT + 20) @(negedge clk_sys);
      chk("wdt off", 8'h00, {alert, 7'(ka_cnt)});
      @(posedge clk_sys);
      wdt_enable <= 1'b1;
      wr(16'h8195);
      wr(16'h9195);
      chk("serviced", 8'h02, {alert, 7'(ka_cnt)});
      repeat (WDT + 10) @(negedge clk_sys);
      chk("alert", 8'h01, {7'h00, alert});
      wr(16'h8194);
      chk("not serviced", 8'h82, {alert, 7'(ka_cnt)});
      wr(16'h8195);
      chk("alert cleared", 8'h03, {alert, 7'(ka_cnt)});
      repeat (WDT + 10) @(negedge clk_sys);
      chk("alert again", 8'h01, {7'h00, alert});
      @(posedge clk_sys);
      wdt_enable <= 1'b0;
      repeat (8) @(negedge clk_sys);
      chk("alert off", 8'h00, {7'h00, alert});
      $display("test watchdog done");
      wr(16'h9555);
      chk("cleared", 8'h00, range_select_bits | {6'h00, alert, status_echo});
      chk("reset count", 8'h01, 8'(sr_cnt));
      $display("test soft reset done");
      give_verdict();
   end
endmodule : testbench
bind skd_decode skd_decode_assertions #(.WDT_CYCLES(WDT_CYCLES), .NUM_CH(NUM_CH)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .sync_n(sync_n), .serial_data_input(serial_data_input),
   .wdt_enable(wdt_enable), .alert(alert), .status_echo(status_echo), .soft_reset(soft_reset),
   .keepalive_seen(keepalive_seen), .range_select_bits(range_select_bits));
